/* File: verilog/acpc_top.sv */
// Channel pin configuration, reference and range settings, software reset.
// Assumes config writes arrive as one-cycle strobes from the serial register logic.
`timescale 1ns/1ps
`include "acpc_cfg.svh"

module acpc_top
	import acpc_pkg::*;
#(
	parameter int RST_CYCLES = `ACPC_RST_CYCLES
)
(
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      cfg_wr,
	input  wire logic [`ACPC_NUM_CH-1:0]   cfg_pin_digital,
	input  wire logic [`ACPC_NUM_CH-1:0]   cfg_gpio_dir_out,
	input  wire logic [`ACPC_NUM_CH-1:0]   cfg_digital_output_levels,
	input  wire logic [`ACPC_NUM_CH-1:0]   cfg_output_drive_type_select,
	input  wire logic                      cfg_int_ref_en,
	input  wire logic                      cfg_range_2x,
	input  wire logic                      cfg_reset_bit,
	input  wire logic [`ACPC_NUM_CH-1:0]   pin_i,
	output logic      [`ACPC_NUM_CH-1:0]   pin_o,
	output logic      [`ACPC_NUM_CH-1:0]   pin_oe,
	output logic      [`ACPC_NUM_CH-1:0]   digital_input_levels,
	output logic      [`ACPC_NUM_CH-1:0]   chan_is_digital,
	output logic      [`ACPC_NUM_CH-1:0]   chan_is_output,
	output logic      [`ACPC_NUM_CH-1:0]   digital_output_levels,
	output logic      [`ACPC_NUM_CH-1:0]   output_drive_type_select,
	output logic                           int_ref_enable,
	output logic                           ext_ref_select,
	output logic                           range_2x,
	output logic                           reset_bit,
	input  wire logic                      conv_start,
	input  wire logic [`ACPC_CH_IDX_W-1:0] conv_channel,
	input  wire logic [`ACPC_SAMPLE_W-1:0] ana_sample_lsb,
	output logic                           conv_ready,
	output logic                           conv_busy,
	output logic                           conv_done,
	output logic      [`ACPC_CODE_W-1:0]   conv_result
);

	localparam logic [`ACPC_RST_CNT_W-1:0] RST_LAST = `ACPC_RST_CNT_W'(RST_CYCLES - 1);

	logic [`ACPC_NUM_CH-1:0]   pin_cfg_q, pin_cfg_d;
	logic [`ACPC_NUM_CH-1:0]   dir_q, dir_d;
	logic [`ACPC_NUM_CH-1:0]   gpo_q, gpo_d;
	logic [`ACPC_NUM_CH-1:0]   drive_q, drive_d;
	logic                      int_ref_q, int_ref_d;
	logic                      range_q, range_d;
	logic                      rst_busy_q, rst_busy_d;
	logic [`ACPC_RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;

	// Software reset holds the config registers, pin cell outputs and conversion timer in their reset state
	wire local_rst  = rst || rst_busy_q;
	wire cfg_take   = cfg_wr && !rst_busy_q;
	wire rst_start  = cfg_take && cfg_reset_bit;
	// Reset write stores none of its other fields
	wire cfg_load   = cfg_take && !cfg_reset_bit;
	wire rst_finish = rst_busy_q && (rst_cnt_q == RST_LAST);
	wire ch_analog  = !pin_cfg_q[conv_channel];
	wire conv_go    = conv_start && ch_analog;

	// Per-channel fields and the reference and range bits, written together on a config strobe
	assign pin_cfg_d = cfg_load ? cfg_pin_digital              : pin_cfg_q;
	assign dir_d     = cfg_load ? cfg_gpio_dir_out             : dir_q;
	assign gpo_d     = cfg_load ? cfg_digital_output_levels    : gpo_q;
	assign drive_d   = cfg_load ? cfg_output_drive_type_select : drive_q;
	assign int_ref_d = cfg_load ? cfg_int_ref_en               : int_ref_q;
	assign range_d   = cfg_load ? cfg_range_2x                 : range_q;

	always_comb begin
		rst_busy_d = rst_busy_q;
		rst_cnt_d  = rst_cnt_q;
		if (rst_start) begin
			rst_busy_d = 1'b1;
			rst_cnt_d  = '0;
		end else if (rst_finish) begin
			rst_busy_d = 1'b0;
			rst_cnt_d  = '0;
		end else if (rst_busy_q) begin
			rst_cnt_d  = rst_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_busy_q <= 1'b0;
			rst_cnt_q  <= '0;
		end else begin
			rst_busy_q <= rst_busy_d;
			rst_cnt_q  <= rst_cnt_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (local_rst) begin
			pin_cfg_q <= `ACPC_PIN_CFG_RST;
			dir_q     <= `ACPC_GPIO_DIR_RST;
			gpo_q     <= `ACPC_GPO_RST;
			drive_q   <= `ACPC_DRIVE_RST;
			int_ref_q <= `ACPC_INT_REF_RST;
			range_q   <= `ACPC_RANGE_RST;
		end else begin
			pin_cfg_q <= pin_cfg_d;
			dir_q     <= dir_d;
			gpo_q     <= gpo_d;
			drive_q   <= drive_d;
			int_ref_q <= int_ref_d;
			range_q   <= range_d;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `ACPC_NUM_CH; gi++) begin : g_ch
			acpc_pin_cell u_cell (
				.core_clk   (core_clk),
				.rst        (local_rst),
				.is_digital (pin_cfg_q[gi]),
				.is_output  (dir_q[gi]),
				.out_level  (gpo_q[gi]),
				.open_drain (drive_q[gi]),
				.pin_i      (pin_i[gi]),
				.pin_o      (pin_o[gi]),
				.pin_oe     (pin_oe[gi]),
				.in_level   (digital_input_levels[gi])
			);
		end
	endgenerate

	acpc_conv_timer u_conv (
		.core_clk   (core_clk),
		.rst        (local_rst),
		.start      (conv_go),
		.range_2x   (range_q),
		.sample_lsb (ana_sample_lsb),
		.ready      (conv_ready),
		.busy       (conv_busy),
		.done       (conv_done),
		.result     (conv_result)
	);

	assign chan_is_digital          = pin_cfg_q;
	assign chan_is_output           = dir_q;
	assign digital_output_levels    = gpo_q;
	assign output_drive_type_select = drive_q;
	assign int_ref_enable           = int_ref_q;
	assign ext_ref_select           = !int_ref_q;
	assign range_2x                 = range_q;
	assign reset_bit                = rst_busy_q;

	property p_rst_analog;
		@(posedge core_clk) disable iff (1'b0)
		rst |=> (pin_cfg_q == 8'h00) ##1 (pin_oe == 8'h00);
	endproperty
	a_rst_analog: assert property (p_rst_analog)
		else $error("channels not analog after reset");

	property p_analog_no_drive;
		@(posedge core_clk) disable iff (local_rst)
		##1 ((pin_oe & ~$past(pin_cfg_q)) == 8'h00);
	endproperty
	a_analog_no_drive: assert property (p_analog_no_drive)
		else $error("analog channel drives its pin");

	property p_input_no_drive;
		@(posedge core_clk) disable iff (local_rst)
		##1 ((pin_oe & ~$past(dir_q)) == 8'h00);
	endproperty
	a_input_no_drive: assert property (p_input_no_drive)
		else $error("input channel drives its pin");

	property p_in_levels_masked;
		@(posedge core_clk) disable iff (local_rst)
		##1 ((digital_input_levels & ~($past(pin_cfg_q) & ~$past(dir_q))) == 8'h00);
	endproperty
	a_in_levels_masked: assert property (p_in_levels_masked)
		else $error("input level shown on non-input channel");

	property p_push_pull_level;
		@(posedge core_clk) disable iff (local_rst)
		##1 (((pin_o ^ $past(gpo_q)) & pin_oe & ~$past(drive_q)) == 8'h00);
	endproperty
	a_push_pull_level: assert property (p_push_pull_level)
		else $error("push-pull output level wrong");

	property p_open_drain_low;
		@(posedge core_clk) disable iff (local_rst)
		##1 ((pin_o & $past(drive_q)) == 8'h00);
	endproperty
	a_open_drain_low: assert property (p_open_drain_low)
		else $error("open-drain channel driven high");

	property p_rst_ref_range;
		@(posedge core_clk) disable iff (1'b0)
		rst |=> (ext_ref_select && !int_ref_enable && !range_2x);
	endproperty
	a_rst_ref_range: assert property (p_rst_ref_range)
		else $error("reference or range not default after reset");

	property p_int_ref_cause;
		@(posedge core_clk) disable iff (rst)
		$rose(int_ref_enable) |-> $past(cfg_load) && $past(cfg_int_ref_en);
	endproperty
	a_int_ref_cause: assert property (p_int_ref_cause)
		else $error("internal reference enabled without write");

	property p_sw_rst_clear;
		@(posedge core_clk) disable iff (rst)
		rst_finish |=> !reset_bit && (pin_cfg_q == 8'h00) && !int_ref_enable;
	endproperty
	a_sw_rst_clear: assert property (p_sw_rst_clear)
		else $error("reset bit did not self-clear with defaults");

	property p_sw_rst_bound;
		@(posedge core_clk) disable iff (rst)
		reset_bit |-> (rst_cnt_q <= RST_LAST);
	endproperty
	a_sw_rst_bound: assert property (p_sw_rst_bound)
		else $error("software reset overran its time");

	property p_conv_back_acq;
		@(posedge core_clk) disable iff (local_rst)
		$fell(conv_busy) |-> conv_done ##1 !conv_busy;
	endproperty
	a_conv_back_acq: assert property (p_conv_back_acq)
		else $error("conversion end not followed by acquisition");

	property p_zero_code;
		@(posedge core_clk) disable iff (local_rst)
		(conv_busy && !$past(conv_busy) && ($past(ana_sample_lsb) == 17'h00000))
			|-> ##190 (conv_done && (conv_result == 16'h0000));
	endproperty
	a_zero_code: assert property (p_zero_code)
		else $error("zero input did not give zero code");

	property p_load_digital;
		@(posedge core_clk) disable iff (local_rst)
		cfg_load |=> (chan_is_digital == $past(cfg_pin_digital));
	endproperty
	a_load_digital: assert property (p_load_digital)
		else $error("channel use not taken from config write");

	property p_load_dir;
		@(posedge core_clk) disable iff (local_rst)
		cfg_load |=> (chan_is_output == $past(cfg_gpio_dir_out));
	endproperty
	a_load_dir: assert property (p_load_dir)
		else $error("channel direction not taken from config write");

	property p_load_out_level;
		@(posedge core_clk) disable iff (local_rst)
		cfg_load |=> (digital_output_levels == $past(cfg_digital_output_levels));
	endproperty
	a_load_out_level: assert property (p_load_out_level)
		else $error("output levels not taken from config write");

	property p_load_drive;
		@(posedge core_clk) disable iff (local_rst)
		cfg_load |=> (output_drive_type_select == $past(cfg_output_drive_type_select));
	endproperty
	a_load_drive: assert property (p_load_drive)
		else $error("drive type not taken from config write");

	property p_load_range;
		@(posedge core_clk) disable iff (local_rst)
		cfg_load |=> (range_2x == $past(cfg_range_2x));
	endproperty
	a_load_range: assert property (p_load_range)
		else $error("range not taken from config write");

	property p_push_pull_drives;
		@(posedge core_clk) disable iff (local_rst)
		##1 ((~pin_oe & $past(pin_cfg_q) & $past(dir_q) & ~$past(drive_q)) == 8'h00);
	endproperty
	a_push_pull_drives: assert property (p_push_pull_drives)
		else $error("push-pull output channel not driving");

	property p_sw_rst_start;
		@(posedge core_clk) disable iff (rst)
		rst_start |=> reset_bit;
	endproperty
	a_sw_rst_start: assert property (p_sw_rst_start)
		else $error("reset bit not set by reset write");

	property p_sw_rst_defaults;
		@(posedge core_clk) disable iff (rst)
		reset_bit |=> (chan_is_digital == 8'h00) && !int_ref_enable && !range_2x;
	endproperty
	a_sw_rst_defaults: assert property (p_sw_rst_defaults)
		else $error("defaults not restored by software reset");

	property p_digital_no_conv;
		@(posedge core_clk) disable iff (local_rst)
		(conv_start && !ch_analog && !conv_busy) |=> !conv_busy;
	endproperty
	a_digital_no_conv: assert property (p_digital_no_conv)
		else $error("conversion started on digital channel");

endmodule

/* File: verilog/acpc_cfg.svh */
// Constants for the channel pin configuration block: sizes, reset values, timing.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef ACPC_CFG_SVH
`define ACPC_CFG_SVH

`define ACPC_NUM_CH        8
`define ACPC_CH_IDX_W      3
`define ACPC_CODE_W        16
`define ACPC_SAMPLE_W      17

// Reset values of the configuration fields
`define ACPC_PIN_CFG_RST   8'h00
`define ACPC_GPIO_DIR_RST  8'h00
`define ACPC_GPO_RST       8'h00
`define ACPC_DRIVE_RST     8'h00
`define ACPC_INT_REF_RST   1'b0
`define ACPC_RANGE_RST     1'b0

// Converter code limits
`define ACPC_CODE_FULL     16'hffff

// Timing figures in their own units
`define ACPC_CLK_MHZ       200
`define ACPC_T_RST_MS      5
`define ACPC_T_CONV_NS     950
`define ACPC_T_ACQ_NS      300

// Cycle counts: longest times round down, least times round up
`define ACPC_RST_CYCLES    (`ACPC_T_RST_MS * `ACPC_CLK_MHZ * 1000)
`define ACPC_CONV_CYCLES   ((`ACPC_T_CONV_NS * `ACPC_CLK_MHZ) / 1000)
`define ACPC_ACQ_CYCLES    ((`ACPC_T_ACQ_NS * `ACPC_CLK_MHZ + 999) / 1000)

`define ACPC_RST_CNT_W     20
`define ACPC_CONV_CNT_W    8

`endif

/* File: verilog/acpc_pkg.sv */
// Types shared by the channel pin configuration block.
// No assumptions beyond a SystemVerilog package scope.
package acpc_pkg;

	typedef enum logic [0:0] {
		ACPC_ST_ACQ,
		ACPC_ST_CONV
	} acpc_conv_state_t;

endpackage

/* File: verilog/acpc_pin_cell.sv */
// One multiplexer channel: digital input sampling and output driver control.
// Assumes pin_i is asynchronous to core_clk and the pad resolves o/oe.
`timescale 1ns/1ps
`include "acpc_cfg.svh"

module acpc_pin_cell
	import acpc_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic is_digital,
	input  wire logic is_output,
	input  wire logic out_level,
	input  wire logic open_drain,
	input  wire logic pin_i,
	output logic      pin_o,
	output logic      pin_oe,
	output logic      in_level
);

	logic sync1_q, sync2_q, sync3_q;
	logic level_q;
	logic pin_o_q, pin_oe_q, in_level_q;
	wire  drive_on  = is_digital && is_output;
	wire  oe_d      = drive_on && (!open_drain || !out_level);
	wire  o_d       = drive_on && !open_drain && out_level;
	wire  in_lvl_d  = is_digital && !is_output && level_q;

	always_ff @(posedge core_clk) begin
		sync1_q <= pin_i;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
	end

	// Level accepted only once two stages agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			level_q <= 1'b0;
		end else if (sync2_q == sync3_q) begin
			level_q <= sync3_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_o_q    <= 1'b0;
			pin_oe_q   <= 1'b0;
			in_level_q <= 1'b0;
		end else begin
			pin_o_q    <= o_d;
			pin_oe_q   <= oe_d;
			in_level_q <= in_lvl_d;
		end
	end

	assign pin_o    = pin_o_q;
	assign pin_oe   = pin_oe_q;
	assign in_level = in_level_q;

endmodule

/* File: verilog/acpc_conv_timer.sv */
// Conversion sequencer: acquisition, timed conversion, result scaling.
// Assumes sample_lsb is the input voltage in steps of reference/65536.
`timescale 1ns/1ps
`include "acpc_cfg.svh"

module acpc_conv_timer
	import acpc_pkg::*;
(
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      start,
	input  wire logic                      range_2x,
	input  wire logic [`ACPC_SAMPLE_W-1:0] sample_lsb,
	output logic                           ready,
	output logic                           busy,
	output logic                           done,
	output logic [`ACPC_CODE_W-1:0]        result
);

	localparam logic [`ACPC_CONV_CNT_W-1:0] CONV_LAST =
		`ACPC_CONV_CNT_W'(`ACPC_CONV_CYCLES - 1);
	localparam logic [`ACPC_CONV_CNT_W-1:0] ACQ_MIN =
		`ACPC_CONV_CNT_W'(`ACPC_ACQ_CYCLES);

	acpc_conv_state_t               state_q, state_d;
	logic [`ACPC_CONV_CNT_W-1:0]    cnt_q, cnt_d;
	logic [`ACPC_SAMPLE_W-1:0]      held_q;
	logic                           held_2x_q;
	logic [`ACPC_CODE_W-1:0]        result_q;
	logic                           done_q;

	wire acq_met  = (cnt_q >= ACQ_MIN);
	wire take     = (state_q == ACPC_ST_ACQ) && acq_met && start;
	wire conv_end = (state_q == ACPC_ST_CONV) && (cnt_q == CONV_LAST);
	// Straight binary; step is full scale / 2^16
	wire [`ACPC_CODE_W-1:0] code_1x = held_q[`ACPC_SAMPLE_W-1] ?
		`ACPC_CODE_FULL : held_q[`ACPC_CODE_W-1:0];
	wire [`ACPC_CODE_W-1:0] code_2x = held_q[`ACPC_SAMPLE_W-1:1];

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ACPC_ST_ACQ: begin
				if (take) begin
					state_d = ACPC_ST_CONV;
					cnt_d   = '0;
				end else if (!acq_met) begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			ACPC_ST_CONV: begin
				if (conv_end) begin
					state_d = ACPC_ST_ACQ;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				state_d = ACPC_ST_ACQ;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ACPC_ST_ACQ;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			held_q    <= '0;
			held_2x_q <= 1'b0;
		end else if (take) begin
			held_q    <= sample_lsb;
			held_2x_q <= range_2x;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q <= '0;
			done_q   <= 1'b0;
		end else begin
			done_q <= conv_end;
			if (conv_end) begin
				result_q <= held_2x_q ? code_2x : code_1x;
			end
		end
	end

	assign ready  = (state_q == ACPC_ST_ACQ) && acq_met;
	assign busy   = (state_q == ACPC_ST_CONV);
	assign done   = done_q;
	assign result = result_q;

endmodule

/* File: bench/acpc_host_model.sv */
// Host-side model that writes configuration and starts conversions.
// Assumes the caller runs in the same clock domain; drives on falling edges.
`timescale 1ns/1ps
`include "acpc_cfg.svh"

module acpc_host_model
	import acpc_pkg::*;
(
	input  wire logic                      core_clk,
	output logic                           cfg_wr,
	output logic [`ACPC_NUM_CH-1:0]        cfg_pin_digital,
	output logic [`ACPC_NUM_CH-1:0]        cfg_gpio_dir_out,
	output logic [`ACPC_NUM_CH-1:0]        cfg_digital_output_levels,
	output logic [`ACPC_NUM_CH-1:0]        cfg_output_drive_type_select,
	output logic                           cfg_int_ref_en,
	output logic                           cfg_range_2x,
	output logic                           cfg_reset_bit,
	output logic                           conv_start,
	output logic [`ACPC_CH_IDX_W-1:0]      conv_channel,
	output logic [`ACPC_SAMPLE_W-1:0]      ana_sample_lsb
);
	initial begin
		{cfg_wr, cfg_int_ref_en, cfg_range_2x, cfg_reset_bit, conv_start} = 5'h00;
		{cfg_pin_digital, cfg_gpio_dir_out} = 16'h0000;
		{cfg_digital_output_levels, cfg_output_drive_type_select} = 16'h0000;
		conv_channel = 3'h0;
		ana_sample_lsb = 17'h00000;
	end

	// Fields other than the reset bit, which is cleared, are inverted once released so stale sampling shows up
	task automatic cfg_write(input logic [7:0] dig, dir, lvl, drv, input logic iref, rng, rstb);
		@(negedge core_clk);
		{cfg_pin_digital, cfg_gpio_dir_out} = {dig, dir};
		{cfg_digital_output_levels, cfg_output_drive_type_select} = {lvl, drv};
		{cfg_int_ref_en, cfg_range_2x, cfg_reset_bit} = {iref, rng, rstb};
		cfg_wr = 1'b1;
		@(negedge core_clk);
		cfg_wr = 1'b0;
		{cfg_pin_digital, cfg_gpio_dir_out} = ~{dig, dir};
		{cfg_digital_output_levels, cfg_output_drive_type_select} = ~{lvl, drv};
		{cfg_int_ref_en, cfg_range_2x, cfg_reset_bit} = {!iref, !rng, 1'b0};
	endtask

	task automatic conv_kick(input logic [2:0] ch, input logic [16:0] smp);
		@(negedge core_clk);
		conv_channel = ch;
		ana_sample_lsb = smp;
		conv_start = 1'b1;
		@(negedge core_clk);
		conv_start = 1'b0;
		ana_sample_lsb = ~smp;
	endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the channel pin configuration block.
// Assumes the host model drives all configuration and conversion inputs.
`timescale 1ns/1ps
`include "acpc_cfg.svh"

module tb_top
	import acpc_pkg::*;
;
	localparam int RST_N = 20;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        cfg_wr, cfg_int_ref_en, cfg_range_2x, cfg_reset_bit, conv_start;
	logic [7:0]  cfg_pin_digital, cfg_gpio_dir_out, cfg_digital_output_levels;
	logic [7:0]  cfg_output_drive_type_select, pin_i, pin_o, pin_oe, digital_input_levels;
	logic [7:0]  chan_is_digital, chan_is_output, digital_output_levels;
	logic [7:0]  output_drive_type_select, dig, dir, lvl, drv;
	logic [7:0]  ext_lvl = 8'h00;
	logic        int_ref_enable, ext_ref_select, range_2x, reset_bit;
	logic        conv_ready, conv_busy, conv_done;
	logic [2:0]  conv_channel;
	logic [16:0] ana_sample_lsb, smp;
	logic [15:0] conv_result;
	logic [15:0] exp_q[$];
	logic [31:0] lfsr = 32'h0001780e;
	logic [31:0] r;
	int          err_count = 0;
	int          compares = 0;
	int          n;
	int          b;

	always #2.5 core_clk = ~core_clk;
	// Pad wire: own drive when enabled, outside level otherwise
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);

	acpc_host_model u_acpc_host_model (.core_clk(core_clk), .cfg_wr(cfg_wr),
		.cfg_pin_digital(cfg_pin_digital), .cfg_gpio_dir_out(cfg_gpio_dir_out),
		.cfg_digital_output_levels(cfg_digital_output_levels),
		.cfg_output_drive_type_select(cfg_output_drive_type_select),
		.cfg_int_ref_en(cfg_int_ref_en), .cfg_range_2x(cfg_range_2x),
		.cfg_reset_bit(cfg_reset_bit), .conv_start(conv_start),
		.conv_channel(conv_channel), .ana_sample_lsb(ana_sample_lsb));

	acpc_top #(.RST_CYCLES(RST_N)) u_acpc_top (.core_clk(core_clk), .rst(rst),
		.cfg_wr(cfg_wr), .cfg_pin_digital(cfg_pin_digital),
		.cfg_gpio_dir_out(cfg_gpio_dir_out),
		.cfg_digital_output_levels(cfg_digital_output_levels),
		.cfg_output_drive_type_select(cfg_output_drive_type_select),
		.cfg_int_ref_en(cfg_int_ref_en), .cfg_range_2x(cfg_range_2x),
		.cfg_reset_bit(cfg_reset_bit), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
		.digital_input_levels(digital_input_levels), .chan_is_digital(chan_is_digital),
		.chan_is_output(chan_is_output), .digital_output_levels(digital_output_levels),
		.output_drive_type_select(output_drive_type_select),
		.int_ref_enable(int_ref_enable), .ext_ref_select(ext_ref_select),
		.range_2x(range_2x), .reset_bit(reset_bit), .conv_start(conv_start),
		.conv_channel(conv_channel), .ana_sample_lsb(ana_sample_lsb),
		.conv_ready(conv_ready), .conv_busy(conv_busy), .conv_done(conv_done),
		.conv_result(conv_result));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic close_out();
		chk("pending_notes", 0, exp_q.size());
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_defaults();
		chk("chan_is_digital", 0, chan_is_digital);
		chk("pin_oe", 0, pin_oe);
		chk("int_ref_enable", 0, int_ref_enable);
		chk("ext_ref_select", 1, ext_ref_select);
		chk("range_2x", 0, range_2x);
	endtask

	task automatic wait_ready();
		n = 0;
		while (conv_ready !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			chk("conv_ready", 1, conv_ready);
			close_out();
		end
	endtask

	task automatic convert(input logic [2:0] ch, input logic [16:0] s, input logic [15:0] ex);
		wait_ready();
		exp_q.push_back(ex);
		u_acpc_host_model.conv_kick(ch, s);
		b = 0;
		n = 0;
		while (conv_done !== 1'b1 && n < 400) begin
			b += (conv_busy === 1'b1);
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			chk("conv_done", 1, conv_done);
			close_out();
		end
		chk("busy_cycles", 190, b);
		chk("conv_ready", 0, conv_ready);
	endtask

	// Result watcher: oldest note against each finished conversion
	always @(negedge core_clk) begin
		if (conv_done === 1'b1) begin
			if (exp_q.size() == 0)
				chk("conv_result_note", 1, 0);
			else
				chk("conv_result", exp_q.pop_front(), conv_result);
		end
	end

	initial begin
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		chk_defaults();
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			{dig, dir, lvl, drv} = rnd();
			u_acpc_host_model.cfg_write(dig, dir, lvl, drv, r[0], r[1], 1'b0);
			repeat (2) @(negedge core_clk);
			chk("chan_is_digital", dig, chan_is_digital);
			chk("chan_is_output", dir, chan_is_output);
			chk("digital_output_levels", lvl, digital_output_levels);
			chk("drive_select", drv, output_drive_type_select);
			chk("int_ref_enable", r[0], int_ref_enable);
			chk("ext_ref_select", !r[0], ext_ref_select);
			chk("range_2x", r[1], range_2x);
			chk("pin_oe", dig & dir & (~drv | ~lvl), pin_oe);
			chk("pin_o", dig & dir & ~drv & lvl, pin_o);
			ext_lvl = r[15:8];
			repeat (8) @(negedge core_clk);
			chk("digital_input_levels", dig & ~dir & ext_lvl, digital_input_levels);
		end
		for (int g = 0; g < 2; g++) begin
			u_acpc_host_model.cfg_write(8'h00, 8'hff, 8'hff, 8'h00, 1'b0, g[0], 1'b0);
			repeat (2) @(negedge core_clk);
			chk("pin_oe", 0, pin_oe);
			for (int k = 0; k < 6; k++) begin
				r = rnd();
				case (k)
					0: smp = 17'h00000;
					1: smp = 17'h00001;
					2: smp = 17'h0ffff;
					3: smp = 17'h10000;
					4: smp = 17'h1ffff;
					default: smp = r[16:0];
				endcase
				convert(k[2:0], smp, g ? smp[16:1] : (smp[16] ? 16'hffff : smp[15:0]));
			end
		end
		u_acpc_host_model.cfg_write(8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
		wait_ready();
		u_acpc_host_model.conv_kick(3'h0, 17'h00005);
		repeat (3) @(negedge core_clk);
		chk("conv_busy", 0, conv_busy);
		u_acpc_host_model.cfg_write(8'hff, 8'hff, 8'h55, 8'h0f, 1'b1, 1'b1, 1'b0);
		u_acpc_host_model.cfg_write(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
		chk("reset_bit", 1, reset_bit);
		u_acpc_host_model.cfg_write(8'hff, 8'hff, 8'hff, 8'h00, 1'b1, 1'b1, 1'b0);
		n = 0;
		while (reset_bit === 1'b1 && n < RST_N + 10) begin
			@(negedge core_clk);
			n++;
		end
		chk("reset_done_in_time", 1, reset_bit === 1'b0 && n <= RST_N);
		chk_defaults();
		close_out();
	end
endmodule
